// *** hw/dph_phy_end.sv ***
/*
 * phy-side end: calibration engine, bus mux into the phy control block,
 * read data return and calibrated read offsets.
 * assumes phy pins on phy_cmd / phy_rd_word / phy_rd_valid and the fabric clock only.
 */
`timescale 1ns/100ps
`include "dph_params.svh"
module dph_phy_end #(
  parameter int unsigned MEM_RST_CYC = `DPH_MEM_RST_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic infrastructure_reset,
  // controller side
  dph_if.phy_mp mc,
  // phy control block side
  output dph_pkg::dph_cmd_t phy_cmd,
  input wire logic [`DPH_WORD_W-1:0] phy_rd_word,
  input wire logic phy_rd_valid
);
  import dph_pkg::*;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    dph_cal_state_t state;
    logic [15:0] cnt;
    logic [5:0] wait_cnt;
    logic [1:0] rank;
    logic [`DPH_LANES-1:0] lane_ok;
    logic [`DPH_OFS_W-1:0] offs;
    logic done;
    logic [`DPH_WORD_W-1:0] rdata;
    logic rvalid;
    dph_cmd_t cmd;
  } dph_phy_st_t;

  dph_phy_st_t st_q;
  dph_phy_st_t st_d;
  dph_cmd_t cal;
  dph_cmd_t ctl;
  logic [`DPH_LANES-1:0] lane_bad;
  logic [63:0] pat;
  logic rst_all;

  ////////////////////////////////////////////////////////////////////////
  // controller bus as a control word
  always_comb begin
    ctl = DPH_CMD_IDLE;
    ctl.ras_n = mc.ctrl_row_strobe_n;
    ctl.cas_n = mc.ctrl_column_strobe_n;
    ctl.we_n = mc.ctrl_write_strobe_n;
    ctl.addr = mc.ctrl_packed_address;
    ctl.bank = mc.ctrl_packed_bank;
    ctl.cs_n = mc.ctrl_chip_select_n;
    ctl.cmd_push_n = mc.ctrl_cmd_fifo_push_n;
    ctl.word_push_n = mc.ctrl_word_fifo_push_n;
    ctl.seq_type = mc.ctrl_seq_type;
    ctl.data_offset = mc.ctrl_data_slot_offset;
    ctl.aux_lo = mc.ctrl_aux_field_low;
    ctl.aux_hi = mc.ctrl_aux_field_high;
    ctl.rank = mc.ctrl_target_rank;
    ctl.wdata = mc.ctrl_write_word;
    ctl.wmask = mc.ctrl_write_mask;
    ctl.wpush = mc.ctrl_write_word_push;
    ctl.mem_reset_n = mc.ctrl_memory_reset_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // lane compare against the calibration pattern
  always_comb begin
    // each byte lane of every memory word
    pat = `DPH_CAL_PATTERN;
    lane_bad = '0;
    for (int w = 0; w < 2 * `DPH_CK_PER_CLK; w++) begin
      for (int l = 0; l < `DPH_LANES; l++) begin
        if (phy_rd_word[w*`DPH_DQ_WIDTH+l*8 +: 8] != pat[63-8*w -: 8]) begin
          lane_bad[l] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration engine and mux
  always_comb begin
    st_d = st_q;
    // two-flop reset synchroniser
    st_d.rst_meta = infrastructure_reset;
    st_d.rst_sync = st_q.rst_meta;
    rst_all = sys_rst | st_q.rst_sync;
    // idle calibration word, selects in slots 0 and 2
    cal = DPH_CMD_IDLE;
    cal.mem_reset_n = (st_q.state != DPH_CAL_RESET);
    cal.rank = st_q.rank;
    cal.cs_n = '1;
    cal.cs_n[0] = 1'b0;
    cal.cs_n[2*`DPH_CS_WIDTH] = 1'b0;
    case (st_q.state)
      DPH_CAL_RESET: begin
        // memory held in reset for a fixed count
        st_d.cnt = st_q.cnt + 16'h0001;
        if (st_q.cnt == 16'(MEM_RST_CYC - 1)) begin
          st_d.cnt = '0;
          st_d.state = DPH_CAL_WRITE;
        end
      end
      DPH_CAL_WRITE: begin
        // pattern write with auto precharge
        cal.ras_n[0] = 1'b0;
        cal.cas_n[2] = 1'b0;
        cal.we_n[2] = 1'b0;
        cal.addr[2*`DPH_ROW_WIDTH+`DPH_AP_BIT] = 1'b1;
        cal.cmd_push_n = 1'b0;
        cal.word_push_n = 1'b0;
        cal.seq_type = `DPH_SEQ_WRITE;
        cal.data_offset = `DPH_CWL + `DPH_COL_SLOT;
        for (int w = 0; w < 2 * `DPH_CK_PER_CLK; w++) begin
          for (int l = 0; l < `DPH_LANES; l++) begin
            cal.wdata[w*`DPH_DQ_WIDTH+l*8 +: 8] = pat[63-8*w -: 8];
          end
        end
        cal.wpush = 1'b1;
        st_d.state = DPH_CAL_READ;
      end
      DPH_CAL_READ: begin
        // read back from the same location
        cal.ras_n[0] = 1'b0;
        cal.cas_n[2] = 1'b0;
        cal.addr[2*`DPH_ROW_WIDTH+`DPH_AP_BIT] = 1'b1;
        cal.cmd_push_n = 1'b0;
        cal.word_push_n = 1'b0;
        cal.seq_type = `DPH_SEQ_READ;
        cal.data_offset = `DPH_CAL_RD_GUESS + `DPH_COL_SLOT - 6'h01;
        st_d.wait_cnt = '0;
        st_d.state = DPH_CAL_WAIT;
      end
      DPH_CAL_WAIT: begin
        // count cycles until read data returns
        st_d.wait_cnt = st_q.wait_cnt + 6'h01;
        if (phy_rd_valid) begin
          st_d.offs[6*st_q.rank[0] +: 6] = st_q.wait_cnt;
          st_d.lane_ok = st_q.lane_ok | ~lane_bad;
          st_d.state = DPH_CAL_CHECK;
        end else if (st_q.wait_cnt == `DPH_RD_TIMEOUT) begin
          st_d.state = DPH_CAL_WRITE;
        end
      end
      DPH_CAL_CHECK: begin
        // retry the rank until every lane matched
        st_d.state = DPH_CAL_WRITE;
        if (&st_q.lane_ok) begin
          if (st_q.rank == 2'(`DPH_RANKS - 1)) begin
            st_d.state = DPH_CAL_DONE;
            st_d.done = 1'b1;
          end else begin
            st_d.rank = st_q.rank + 2'h1;
            st_d.lane_ok = '0;
          end
        end
      end
      DPH_CAL_DONE: begin
        // stays here until reset
        st_d.done = 1'b1;
      end
      default: begin
        st_d.state = DPH_CAL_RESET;
      end
    endcase
    // handover on the same edge that raises done
    st_d.cmd = st_d.done ? ctl : cal;
    st_d.rdata = phy_rd_word;
    st_d.rvalid = phy_rd_valid & st_d.done;
    // whole engine restarts on either reset
    if (rst_all) begin
      st_d.state = DPH_CAL_RESET;
      st_d.cnt = '0;
      st_d.wait_cnt = '0;
      st_d.rank = '0;
      st_d.lane_ok = '0;
      st_d.offs = '0;
      st_d.done = 1'b0;
      st_d.rdata = '0;
      st_d.rvalid = 1'b0;
      st_d.cmd = DPH_CMD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.cmd <= DPH_CMD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign phy_cmd = st_q.cmd;
  assign mc.phy_read_word = st_q.rdata;
  assign mc.phy_read_valid = st_q.rvalid;
  assign mc.calib_read_offset = st_q.offs;
  assign mc.calib_done = st_q.done;

endmodule

// *** hw/dph_params.svh ***
/*
 * constants of the controller-to-phy handoff: widths, encodings, timing.
 * assumes a single fabric clock at 4 ns and ddr3 memory behind the phy.
 */
// Function
// - calibration engine builds phy control words itself
// - raise calibration done when calibration finishes
// - mux buses: engine in calibration, controller after
// - controller sends commands already in phy format
// - all crossing signals launched, sampled on fabric clock
// - interface reset is synchronised infrastructure reset; code also resets on raw sys_rst, which alone resets the controller end
// - phy clock quarter of memory clock
// - frequency reference equals or divides memory reference
// - strobe vector bit 0 is first slot
// - lowest address and bank slice is first slot
// - lowest chip select slice is first slot
// - memory reset bypasses output fifo
// - write, mask and read data eightfold wide
// - high write push loads dq fifo
// - low pushes load command and control fifos
// - sequence type: 4 none, 1 write, 3 read
// - data offset zero, write latency or read offset
// - two aux fields drive odt and cke
// - two-bit rank field selects target rank
// - read valid marks valid read data
// - six-bit read offset per rank output
// - done only after every lane calibrated
`ifndef DPH_PARAMS_SVH
`define DPH_PARAMS_SVH

`define DPH_CLK_PERIOD_NS 4
`define DPH_CK_PER_CLK 4
`define DPH_FREQ_REF_DIV_LOW 2
`define DPH_DQ_WIDTH 16
`define DPH_LANES 2
`define DPH_ROW_WIDTH 14
`define DPH_BANK_WIDTH 3
`define DPH_CS_WIDTH 1
`define DPH_SEL_PER_RANK 1
`define DPH_RANKS 2
`define DPH_COL_WIDTH 10
`define DPH_AP_BIT 10

`define DPH_WORD_W (2 * `DPH_CK_PER_CLK * `DPH_DQ_WIDTH)
`define DPH_MASK_W (2 * `DPH_CK_PER_CLK * (`DPH_DQ_WIDTH / 8))
`define DPH_ADDR_W (`DPH_ROW_WIDTH * `DPH_CK_PER_CLK)
`define DPH_BANK_W (`DPH_BANK_WIDTH * `DPH_CK_PER_CLK)
`define DPH_CSN_W (`DPH_CS_WIDTH * `DPH_SEL_PER_RANK * `DPH_CK_PER_CLK)
`define DPH_OFS_W (6 * `DPH_RANKS)

`define DPH_SEQ_NONE 3'h4
`define DPH_SEQ_WRITE 3'h1
`define DPH_SEQ_READ 3'h3
`define DPH_COL_SLOT 6'h02
`define DPH_CWL 6'h05
`define DPH_CAL_RD_GUESS 6'h01
`define DPH_RD_TIMEOUT 6'h3f
`define DPH_CAL_PATTERN 64'hff00_aa55_55aa_9966

`define DPH_MEM_RST_NS 200000
`define DPH_MEM_RST_CYC (`DPH_MEM_RST_NS / `DPH_CLK_PERIOD_NS)

`endif

// *** hw/dph_pkg.sv ***
/*
 * types shared by both ends of the handoff.
 * assumes dph_params.svh is on the include path.
 */
`include "dph_params.svh"
package dph_pkg;

  typedef logic [`DPH_CK_PER_CLK-1:0] dph_slot_t;

  typedef struct packed {
    dph_slot_t ras_n;
    dph_slot_t cas_n;
    dph_slot_t we_n;
    logic [`DPH_ADDR_W-1:0] addr;
    logic [`DPH_BANK_W-1:0] bank;
    logic [`DPH_CSN_W-1:0] cs_n;
    logic cmd_push_n;
    logic word_push_n;
    logic [2:0] seq_type;
    logic [5:0] data_offset;
    logic [3:0] aux_lo;
    logic [3:0] aux_hi;
    logic [1:0] rank;
    logic [`DPH_WORD_W-1:0] wdata;
    logic [`DPH_MASK_W-1:0] wmask;
    logic wpush;
    logic mem_reset_n;
  } dph_cmd_t;

  localparam dph_cmd_t DPH_CMD_IDLE = '{
    ras_n: '1, cas_n: '1, we_n: '1, addr: '0, bank: '0, cs_n: '1,
    cmd_push_n: 1'b1, word_push_n: 1'b1, seq_type: `DPH_SEQ_NONE,
    data_offset: 6'h00, aux_lo: 4'h0, aux_hi: 4'h0, rank: 2'h0,
    wdata: '0, wmask: '0, wpush: 1'b0, mem_reset_n: 1'b0};

  typedef enum logic [2:0] {
    DPH_CAL_RESET = 3'b000,
    DPH_CAL_WRITE = 3'b001,
    DPH_CAL_READ = 3'b011,
    DPH_CAL_WAIT = 3'b010,
    DPH_CAL_CHECK = 3'b110,
    DPH_CAL_DONE = 3'b111
  } dph_cal_state_t;

endpackage

// *** hw/dph_if.sv ***
/*
 * controller-to-phy handoff signals with one modport per end.
 * assumes both ends run on the same fabric clock.
 */
`timescale 1ns/100ps
`include "dph_params.svh"
interface dph_if;
  logic [`DPH_CK_PER_CLK-1:0] ctrl_row_strobe_n;
  logic [`DPH_CK_PER_CLK-1:0] ctrl_column_strobe_n;
  logic [`DPH_CK_PER_CLK-1:0] ctrl_write_strobe_n;
  logic [`DPH_ADDR_W-1:0] ctrl_packed_address;
  logic [`DPH_BANK_W-1:0] ctrl_packed_bank;
  logic [`DPH_CSN_W-1:0] ctrl_chip_select_n;
  logic ctrl_memory_reset_n;
  logic [`DPH_WORD_W-1:0] ctrl_write_word;
  logic [`DPH_MASK_W-1:0] ctrl_write_mask;
  logic ctrl_write_word_push;
  logic ctrl_cmd_fifo_push_n;
  logic ctrl_word_fifo_push_n;
  logic [2:0] ctrl_seq_type;
  logic [5:0] ctrl_data_slot_offset;
  logic [3:0] ctrl_aux_field_low;
  logic [3:0] ctrl_aux_field_high;
  logic [1:0] ctrl_target_rank;
  logic [`DPH_WORD_W-1:0] phy_read_word;
  logic phy_read_valid;
  logic [`DPH_OFS_W-1:0] calib_read_offset;
  logic calib_done;

  modport ctrl_mp (
    output ctrl_row_strobe_n, ctrl_column_strobe_n, ctrl_write_strobe_n,
    output ctrl_packed_address, ctrl_packed_bank, ctrl_chip_select_n,
    output ctrl_memory_reset_n, ctrl_write_word, ctrl_write_mask,
    output ctrl_write_word_push, ctrl_cmd_fifo_push_n,
    output ctrl_word_fifo_push_n, ctrl_seq_type, ctrl_data_slot_offset,
    output ctrl_aux_field_low, ctrl_aux_field_high, ctrl_target_rank,
    input phy_read_word, phy_read_valid, calib_read_offset, calib_done
  );

  modport phy_mp (
    input ctrl_row_strobe_n, ctrl_column_strobe_n, ctrl_write_strobe_n,
    input ctrl_packed_address, ctrl_packed_bank, ctrl_chip_select_n,
    input ctrl_memory_reset_n, ctrl_write_word, ctrl_write_mask,
    input ctrl_write_word_push, ctrl_cmd_fifo_push_n,
    input ctrl_word_fifo_push_n, ctrl_seq_type, ctrl_data_slot_offset,
    input ctrl_aux_field_low, ctrl_aux_field_high, ctrl_target_rank,
    output phy_read_word, phy_read_valid, calib_read_offset, calib_done
  );
endinterface

// *** hw/dph_ctrl_end.sv ***
/*
 * controller-side end: turns one user request per cycle into a packed
 * quarter-rate command word; returns read data to the user.
 * assumes the phy end drives calib_done and read offsets.
 */
`timescale 1ns/100ps
`include "dph_params.svh"
module dph_ctrl_end (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // phy side
  dph_if.ctrl_mp mc,
  // user request
  input wire logic user_valid,
  input wire logic user_write,
  input wire logic [1:0] user_rank,
  input wire logic [`DPH_ROW_WIDTH-1:0] user_row,
  input wire logic [`DPH_BANK_WIDTH-1:0] user_bank,
  input wire logic [`DPH_COL_WIDTH-1:0] user_col,
  input wire logic [3:0] user_aux_low,
  input wire logic [3:0] user_aux_high,
  input wire logic [`DPH_WORD_W-1:0] user_wdata,
  input wire logic [`DPH_MASK_W-1:0] user_wmask,
  // user answer
  output logic user_ready,
  output logic [`DPH_WORD_W-1:0] user_rdata,
  output logic user_rvalid
);
  import dph_pkg::*;

  typedef struct packed {
    logic ready;
    logic [`DPH_WORD_W-1:0] rdata;
    logic rvalid;
    dph_cmd_t cmd;
  } dph_ctrl_st_t;

  dph_ctrl_st_t st_q;
  dph_ctrl_st_t st_d;
  logic [5:0] rd_ofs;

  ////////////////////////////////////////////////////////////////////////
  // command word assembly
  always_comb begin
    st_d = st_q;
    st_d.cmd = DPH_CMD_IDLE;
    st_d.cmd.mem_reset_n = 1'b1;
    rd_ofs = mc.calib_read_offset[6*user_rank[0] +: 6];
    st_d.ready = mc.calib_done;
    if (user_valid && st_q.ready) begin
      st_d.cmd.ras_n[0] = 1'b0;
      st_d.cmd.cas_n[2] = 1'b0;
      st_d.cmd.we_n[2] = ~user_write;
      st_d.cmd.addr[0 +: `DPH_ROW_WIDTH] = user_row;
      st_d.cmd.addr[2*`DPH_ROW_WIDTH +: `DPH_COL_WIDTH] = user_col;
      st_d.cmd.addr[2*`DPH_ROW_WIDTH+`DPH_AP_BIT] = 1'b1;
      st_d.cmd.bank[0 +: `DPH_BANK_WIDTH] = user_bank;
      st_d.cmd.bank[2*`DPH_BANK_WIDTH +: `DPH_BANK_WIDTH] = user_bank;
      st_d.cmd.cs_n[0] = 1'b0;
      st_d.cmd.cs_n[2*`DPH_CS_WIDTH] = 1'b0;
      st_d.cmd.cmd_push_n = 1'b0;
      st_d.cmd.word_push_n = 1'b0;
      st_d.cmd.aux_lo = user_aux_low;
      st_d.cmd.aux_hi = user_aux_high;
      st_d.cmd.rank = user_rank;
      if (user_write) begin
        st_d.cmd.seq_type = `DPH_SEQ_WRITE;
        st_d.cmd.data_offset = `DPH_CWL + `DPH_COL_SLOT;
        st_d.cmd.wdata = user_wdata;
        st_d.cmd.wmask = user_wmask;
        st_d.cmd.wpush = 1'b1;
      end else begin
        st_d.cmd.seq_type = `DPH_SEQ_READ;
        st_d.cmd.data_offset = rd_ofs + `DPH_COL_SLOT - 6'h01;
      end
    end
    st_d.rdata = mc.phy_read_word;
    st_d.rvalid = mc.phy_read_valid;
    if (sys_rst) begin
      st_d.ready = 1'b0;
      st_d.rvalid = 1'b0;
      st_d.rdata = '0;
      st_d.cmd = DPH_CMD_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign user_ready = st_q.ready;
  assign user_rdata = st_q.rdata;
  assign user_rvalid = st_q.rvalid;
  assign mc.ctrl_row_strobe_n = st_q.cmd.ras_n;
  assign mc.ctrl_column_strobe_n = st_q.cmd.cas_n;
  assign mc.ctrl_write_strobe_n = st_q.cmd.we_n;
  assign mc.ctrl_packed_address = st_q.cmd.addr;
  assign mc.ctrl_packed_bank = st_q.cmd.bank;
  assign mc.ctrl_chip_select_n = st_q.cmd.cs_n;
  assign mc.ctrl_memory_reset_n = st_q.cmd.mem_reset_n;
  assign mc.ctrl_write_word = st_q.cmd.wdata;
  assign mc.ctrl_write_mask = st_q.cmd.wmask;
  assign mc.ctrl_write_word_push = st_q.cmd.wpush;
  assign mc.ctrl_cmd_fifo_push_n = st_q.cmd.cmd_push_n;
  assign mc.ctrl_word_fifo_push_n = st_q.cmd.word_push_n;
  assign mc.ctrl_seq_type = st_q.cmd.seq_type;
  assign mc.ctrl_data_slot_offset = st_q.cmd.data_offset;
  assign mc.ctrl_aux_field_low = st_q.cmd.aux_lo;
  assign mc.ctrl_aux_field_high = st_q.cmd.aux_hi;
  assign mc.ctrl_target_rank = st_q.cmd.rank;

endmodule

// *** verif/dph_handoff_props.sv ***
/*
 * concurrent checks on the controller-to-phy handoff signals.
 * assumes instantiation beside the interface, one fabric clock.
 */
`timescale 1ns/100ps
`include "dph_params.svh"
module dph_handoff_props (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // controller word
  input wire logic [`DPH_CK_PER_CLK-1:0] ctrl_row_strobe_n,
  input wire logic [`DPH_CK_PER_CLK-1:0] ctrl_column_strobe_n,
  input wire logic [`DPH_CK_PER_CLK-1:0] ctrl_write_strobe_n,
  input wire logic [`DPH_CSN_W-1:0] ctrl_chip_select_n,
  input wire logic ctrl_write_word_push,
  input wire logic ctrl_cmd_fifo_push_n,
  input wire logic ctrl_word_fifo_push_n,
  input wire logic [2:0] ctrl_seq_type,
  input wire logic [5:0] ctrl_data_slot_offset,
  input wire logic [1:0] ctrl_target_rank,
  // phy answers
  input wire logic phy_read_valid,
  input wire logic [`DPH_OFS_W-1:0] calib_read_offset,
  input wire logic calib_done
);
  logic [5:0] rd_ofs;
  assign rd_ofs = calib_read_offset[6*ctrl_target_rank[0] +: 6]
    + `DPH_COL_SLOT - 6'h01;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_cmd;
    !ctrl_cmd_fifo_push_n && !ctrl_word_fifo_push_n;
  endsequence
  sequence s_wr;
    s_cmd ##0 !ctrl_write_strobe_n[2];
  endsequence
  sequence s_rd;
    s_cmd ##0 (ctrl_write_strobe_n[2] && !ctrl_column_strobe_n[2]);
  endsequence

  AST_DONE_HOLD: assert property (calib_done |=> calib_done)
    else $error("calibration done dropped");
  AST_NO_EARLY_CMD: assert property (
    !calib_done |-> ctrl_cmd_fifo_push_n && ctrl_word_fifo_push_n)
    else $error("command before calibration done");
  AST_FIRST_CMD: assert property (
    $rose(calib_done) |-> ctrl_cmd_fifo_push_n [*2])
    else $error("command too soon after handover");
  AST_WR_TYPE: assert property (
    s_wr |-> ctrl_seq_type == `DPH_SEQ_WRITE)
    else $error("write sequence type wrong");
  AST_RD_TYPE: assert property (
    s_rd |-> ctrl_seq_type == `DPH_SEQ_READ)
    else $error("read sequence type wrong");
  AST_WR_OFS: assert property (
    s_wr |-> ctrl_data_slot_offset == `DPH_CWL + `DPH_COL_SLOT)
    else $error("write data offset wrong");
  AST_RD_OFS: assert property (
    s_rd |-> ctrl_data_slot_offset == rd_ofs)
    else $error("read data offset wrong");
  AST_WPUSH: assert property (
    ctrl_write_word_push |-> !ctrl_write_strobe_n[2] && !ctrl_cmd_fifo_push_n)
    else $error("write push without write command");
  AST_SLOT0_ACT: assert property (
    s_cmd |-> !ctrl_row_strobe_n[0] && ctrl_row_strobe_n[3:1] == 3'h7)
    else $error("activate not in first slot");
  AST_SLOT0_CS: assert property (
    s_cmd |-> !ctrl_chip_select_n[0])
    else $error("chip select not in first slot");
  AST_RVALID: assert property (phy_read_valid |-> calib_done)
    else $error("read valid before calibration done");
  AST_OFS_HOLD: assert property (
    calib_done |=> $stable(calib_read_offset))
    else $error("read offset moved after calibration");
endmodule

// *** verif/tb.sv ***
/*
 * bench: both ends joined, simple phy memory, model of command words.
 * assumes design files compiled first, checker beside the interface.
 */
`timescale 1ns/100ps
`include "dph_params.svh"
module tb;
  import dph_pkg::*;
  localparam int RW = `DPH_ROW_WIDTH;
  localparam int BW = `DPH_BANK_WIDTH;
  logic clock, sys_rst, user_valid, user_write, user_ready, user_rvalid;
  logic [1:0] user_rank;
  logic [RW-1:0] user_row;
  logic [BW-1:0] user_bank;
  logic [`DPH_COL_WIDTH-1:0] user_col;
  logic [3:0] user_aux_low, user_aux_high;
  logic [`DPH_WORD_W-1:0] user_wdata, user_rdata, mem_word;
  logic [`DPH_WORD_W-1:0] last_wr, pat;
  logic [`DPH_WORD_W-1:0] phy_rd_word = '0;
  logic [`DPH_MASK_W-1:0] user_wmask;
  logic [3:0] rd_pipe = '0;
  logic phy_rd_valid = 1'b0;
  logic infra_rst;
  dph_cmd_t phy_cmd, ctrl_view;
  dph_cmd_t cq[$], pq[$];
  logic [`DPH_WORD_W-1:0] rdq[$], rq[$];
  int fails, cmp_count, n, ph, r;

  dph_if bus();
  assign ctrl_view = {bus.ctrl_row_strobe_n, bus.ctrl_column_strobe_n,
    bus.ctrl_write_strobe_n, bus.ctrl_packed_address, bus.ctrl_packed_bank,
    bus.ctrl_chip_select_n, bus.ctrl_cmd_fifo_push_n,
    bus.ctrl_word_fifo_push_n, bus.ctrl_seq_type, bus.ctrl_data_slot_offset,
    bus.ctrl_aux_field_low, bus.ctrl_aux_field_high, bus.ctrl_target_rank,
    bus.ctrl_write_word, bus.ctrl_write_mask, bus.ctrl_write_word_push,
    bus.ctrl_memory_reset_n};

  dph_ctrl_end dph_ctrl_end_i (.clock(clock), .sys_rst(sys_rst), .mc(bus),
    .user_valid(user_valid), .user_write(user_write),
    .user_rank(user_rank), .user_row(user_row), .user_bank(user_bank),
    .user_col(user_col), .user_aux_low(user_aux_low),
    .user_aux_high(user_aux_high), .user_wdata(user_wdata),
    .user_wmask(user_wmask), .user_ready(user_ready),
    .user_rdata(user_rdata), .user_rvalid(user_rvalid));
  dph_phy_end #(.MEM_RST_CYC(8)) dph_phy_end_i (.clock(clock),
    .sys_rst(sys_rst), .infrastructure_reset(infra_rst), .mc(bus),
    .phy_cmd(phy_cmd), .phy_rd_word(phy_rd_word),
    .phy_rd_valid(phy_rd_valid));
  dph_handoff_props dph_handoff_props_i (.clock(clock), .sys_rst(sys_rst),
    .ctrl_row_strobe_n(bus.ctrl_row_strobe_n),
    .ctrl_column_strobe_n(bus.ctrl_column_strobe_n),
    .ctrl_write_strobe_n(bus.ctrl_write_strobe_n),
    .ctrl_chip_select_n(bus.ctrl_chip_select_n),
    .ctrl_write_word_push(bus.ctrl_write_word_push),
    .ctrl_cmd_fifo_push_n(bus.ctrl_cmd_fifo_push_n),
    .ctrl_word_fifo_push_n(bus.ctrl_word_fifo_push_n),
    .ctrl_seq_type(bus.ctrl_seq_type),
    .ctrl_data_slot_offset(bus.ctrl_data_slot_offset),
    .ctrl_target_rank(bus.ctrl_target_rank),
    .phy_read_valid(bus.phy_read_valid),
    .calib_read_offset(bus.calib_read_offset), .calib_done(bus.calib_done));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [`DPH_WORD_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("counts: %0d compared, %0d wrong", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [2*RW+2*BW-1:0] slots(input dph_cmd_t c);
    return {c.addr[RW-1:0], c.addr[2*RW +: RW], c.bank[BW-1:0],
      c.bank[2*BW +: BW]};
  endfunction

  task automatic cmp_cmd(input dph_cmd_t g, input dph_cmd_t e);
    check({g.ras_n, g.cas_n, g.we_n}, {e.ras_n, e.cas_n, e.we_n});
    check(slots(g), slots(e));
    check(g.cs_n, e.cs_n);
    check({g.cmd_push_n, g.word_push_n}, 2'h0);
    check(g.seq_type, e.seq_type);
    check(g.data_offset, e.data_offset);
    check({g.aux_lo, g.aux_hi}, {e.aux_lo, e.aux_hi});
    check(g.rank, e.rank);
    check(g.wpush, e.wpush);
    check(g.mem_reset_n, 1'b1);
    if (e.wpush) begin
      check(g.wdata, e.wdata);
      check(g.wmask, e.wmask);
    end
  endtask

  task automatic send(input bit wr);
    dph_cmd_t e;
    user_write = wr;
    user_rank = 2'($urandom_range(1));
    user_row = RW'($urandom);
    user_bank = BW'($urandom);
    user_col = `DPH_COL_WIDTH'($urandom);
    {user_aux_low, user_aux_high} = 8'($urandom);
    user_wdata = {$urandom, $urandom, $urandom, $urandom};
    user_wmask = `DPH_MASK_W'($urandom);
    e = DPH_CMD_IDLE;
    e.ras_n = 4'he;
    e.cas_n = 4'hb;
    e.we_n = wr ? 4'hb : 4'hf;
    e.cs_n = 4'ha;
    e.addr[RW-1:0] = user_row;
    e.addr[2*RW +: RW] = RW'({1'b1, user_col});
    e.bank[BW-1:0] = user_bank;
    e.bank[2*BW +: BW] = user_bank;
    e.seq_type = wr ? `DPH_SEQ_WRITE : `DPH_SEQ_READ;
    e.data_offset = wr ? `DPH_CWL + `DPH_COL_SLOT :
      bus.calib_read_offset[6*user_rank[0] +: 6] + `DPH_COL_SLOT - 6'h01;
    {e.aux_lo, e.aux_hi} = {user_aux_low, user_aux_high};
    e.rank = user_rank;
    e.wpush = wr;
    e.wdata = user_wdata;
    e.wmask = user_wmask;
    cq.push_back(e);
    if (wr) last_wr = user_wdata;
    else rdq.push_back(last_wr);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // phy memory: keeps last write, answers reads four cycles later
  always @(posedge clock) begin
    if (phy_cmd.wpush) mem_word = phy_cmd.wdata;
    if (!phy_cmd.word_push_n && phy_cmd.seq_type == `DPH_SEQ_READ)
      rq.push_back(mem_word);
    rd_pipe <= #1 {rd_pipe[2:0], !phy_cmd.word_push_n &&
      phy_cmd.seq_type == `DPH_SEQ_READ};
    phy_rd_valid <= #1 rd_pipe[2];
    phy_rd_word <= #1 (rd_pipe[2] && rq.size() > 0) ? rq.pop_front() :
      ~phy_rd_word;
  end

  always @(negedge clock) begin
    if (!bus.calib_done && phy_cmd.wpush) check(phy_cmd.wdata, pat);
    if (!phy_cmd.cmd_push_n && bus.calib_done) begin
      if (pq.size() == 0) check(1'b1, 1'b0);
      else cmp_cmd(phy_cmd, pq.pop_front());
    end
    if (!ctrl_view.cmd_push_n) begin
      if (cq.size() == 0) check(1'b1, 1'b0);
      else begin
        pq.push_back(cq[0]);
        cmp_cmd(ctrl_view, cq.pop_front());
      end
    end
    if (user_rvalid) begin
      if (rdq.size() == 0) check(1'b1, 1'b0);
      else check(user_rdata, rdq.pop_front());
    end
  end

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    {sys_rst, user_valid, user_write, user_rank, user_row} = '0;
    {user_bank, user_col, user_aux_low, user_aux_high} = '0;
    {user_wdata, user_wmask} = '0;
    for (n = 0; n < 8; n++) pat[16*n +: 16] =
      {2{8'(`DPH_CAL_PATTERN >> (56 - 8*n))}};
    r = $urandom(68067);
    for (ph = 0; ph < 2; ph++) begin
      sys_rst = 1'b1;
      infra_rst = (ph == 1);
      last_wr = pat;
      repeat (8) @(posedge clock);
      #1 sys_rst = 1'b0;
      check({bus.calib_done, user_ready}, 2'h0);
      if (ph == 1) begin
        repeat (40) @(posedge clock);
        #1 check(bus.calib_done, 1'b0);
      end
      infra_rst = 1'b0;
      for (n = 0; n < 2000 && !user_ready; n++) begin
        user_valid = 1'($urandom);
        user_write = 1'($urandom);
        @(posedge clock);
        #1;
      end
      user_valid = 1'b0;
      if (!user_ready) begin
        fails++;
        stop_test();
      end
      check(bus.calib_done, 1'b1);
      check(bus.calib_read_offset[11:6], bus.calib_read_offset[5:0]);
      for (n = 0; n < 80; n++) begin
        user_valid = ($urandom_range(3) != 0);
        if (user_valid) send(1'($urandom_range(1)));
        @(posedge clock);
        #1;
      end
      user_valid = 1'b0;
      repeat (12) @(posedge clock);
      check(cq.size() + pq.size() + rdq.size(), 0);
      #1;
    end
    stop_test();
  end
endmodule
